/* inc/wdt_pkg.sv */
package wdt_pkg;

    // ----------------------------------------------------------------
    // register map (word indexes; byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int unsigned WDT_IDX_W = 30;
    localparam logic [29:0] WDT_IDX_PERIOD_SEL = 30'h0000FF42;
    localparam logic [29:0] WDT_IDX_MODE = 30'h0000FF43;
    localparam logic [29:0] WDT_IDX_IRQ = 30'h0000FF44;

    localparam int unsigned WDT_REG_W = 8;
    localparam int unsigned WDT_BUS_W = 32;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int unsigned WDT_PSEL_W = 3;
    localparam int unsigned WDT_MODE_RUN_BIT = 7;
    localparam int unsigned WDT_MODE_EN_BIT = 4;
    localparam int unsigned WDT_MODE_RSEL_BIT = 3;
    localparam int unsigned WDT_IRQ_FLAG_BIT = 0;
    localparam int unsigned WDT_IRQ_MASK_BIT = 1;
    localparam int unsigned WDT_IRQ_PRIO_BIT = 2;

    localparam logic [7:0] WDT_PSEL_RST = 8'h00;
    localparam logic [7:0] WDT_MODE_RST = 8'h00;
    localparam logic [7:0] WDT_IRQ_RST = 8'h06;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    // low stage kept at 2^4 cycles: under 0.5% of the shortest period
    localparam int unsigned WDT_PRE_BITS = 4;
    localparam int unsigned WDT_MAX_EXP = 20;

    typedef logic [7:0][4:0] wdt_exp_tab_t;
    // period exponents for select codes 7 down to 0
    localparam wdt_exp_tab_t WDT_OVF_EXP = {5'h14, 5'h12, 5'h11, 5'h10,
                                            5'h0F, 5'h0E, 5'h0D, 5'h0C};

    // ----------------------------------------------------------------
    // bus and mode encodings
    // ----------------------------------------------------------------
    localparam int unsigned WDT_HTRANS_ACT_BIT = 1;

    typedef enum logic [1:0]
    {
        WDT_MODE_INTERVAL,
        WDT_MODE_NMI,
        WDT_MODE_RESET
    } wdt_mode_t;

endpackage

/* inc/wdt_tick_if.sv */
`timescale 1ns/1ps

interface wdt_tick_if;
    logic run_en;
    logic tick;

    modport src
    (
        input run_en,
        output tick
    );

    modport dst
    (
        output run_en,
        input tick
    );
endinterface // wdt_tick_if

/* verilog/wdt_prescale.sv */
`timescale 1ns/1ps

module wdt_prescale #(
    parameter int unsigned PRE_BITS = wdt_pkg::WDT_PRE_BITS
) (
    input wire logic clk,
    input wire logic reset_n,
    wdt_tick_if.src tk
);

    logic [PRE_BITS-1:0] pre_cnt;

    // ----------------------------------------------------------------
    // low stage
    // ----------------------------------------------------------------
    // never cleared by a restart, only frozen
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pre_cnt <= '0;
        else if (tk.run_en)
            pre_cnt <= pre_cnt + PRE_BITS'(1);
    end

    assign tk.tick = tk.run_en & (&pre_cnt);

endmodule // wdt_prescale

/* verilog/wdt_timer.sv */
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// - select code picks period 2^12..2^18, 2^20
// - reset clears period select and mode registers, interval mode
// - run bit clears counter and starts counting
// - run bit sticky until hardware reset
// - mode bits pick interval, nmi or reset
// - mode bits sticky until hardware reset
// - restart leaves low stage running, slight early
// - enabling watchdog with flag set gives nmi
// - counts in halt, freezes in stop
// - interval irq obeys mask flag; priority bit only passed out
// - interval irq has top default priority

module wdt_timer #(
    parameter wdt_pkg::wdt_exp_tab_t OVF_EXP = wdt_pkg::WDT_OVF_EXP,
    parameter int unsigned PRE_BITS = wdt_pkg::WDT_PRE_BITS
) (
    input wire logic clk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // system side
    input wire logic halt_mode,
    input wire logic stop_mode,
    input wire logic irq_ack,
    output logic wd_interval_irq,
    output logic wd_irq_priority,
    output logic nmi_req,
    output logic sys_reset_req
);

    localparam int unsigned CNT_W = wdt_pkg::WDT_MAX_EXP - PRE_BITS;
    localparam int unsigned RW = wdt_pkg::WDT_REG_W;

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    logic [wdt_pkg::WDT_PSEL_W-1:0] period_sel;
    logic run;
    logic watchdog_enable_bit;
    logic reset_select_bit;
    logic wd_irq_flag;
    logic wd_irq_mask;
    logic [CNT_W-1:0] count;

    logic dph_write;
    logic [wdt_pkg::WDT_IDX_W-1:0] dph_idx;

    logic addr_phase;
    logic wr_psel;
    logic wr_mode;
    logic wr_irq;
    logic restart;
    logic at_limit;
    logic overflow;
    logic en_with_flag;
    logic [CNT_W-1:0] limit;
    logic [RW-1:0] wbyte;
    logic [RW-1:0] next_rdata;
    wdt_pkg::wdt_mode_t mode;

    wdt_tick_if tk ();

    // ----------------------------------------------------------------
    // bus front end
    // ----------------------------------------------------------------
    assign addr_phase = hsel & hready & htrans[wdt_pkg::WDT_HTRANS_ACT_BIT];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dph_write <= 1'h0;
            dph_idx <= '0;
        end
        else if (hready)
        begin
            dph_write <= addr_phase & hwrite;
            dph_idx <= haddr[31:2];
        end
    end

    // zero wait state; answer is always okay
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hreadyout <= 1'h1;
            hresp <= 1'h0;
        end
        else
        begin
            hreadyout <= 1'h1;
            hresp <= 1'h0;
        end
    end

    assign wbyte = hwdata[RW-1:0];
    assign wr_psel = dph_write && dph_idx == wdt_pkg::WDT_IDX_PERIOD_SEL;
    assign wr_mode = dph_write && dph_idx == wdt_pkg::WDT_IDX_MODE;
    assign wr_irq = dph_write && dph_idx == wdt_pkg::WDT_IDX_IRQ;

    // read data sampled in the address phase; the master never overlaps
    // a read address with a write data phase, so no bypass is needed
    always_comb
    begin
        next_rdata = '0;
        case (haddr[31:2])
            wdt_pkg::WDT_IDX_PERIOD_SEL:
                next_rdata[wdt_pkg::WDT_PSEL_W-1:0] = period_sel;
            wdt_pkg::WDT_IDX_MODE:
            begin
                next_rdata[wdt_pkg::WDT_MODE_RUN_BIT] = run;
                next_rdata[wdt_pkg::WDT_MODE_EN_BIT] = watchdog_enable_bit;
                next_rdata[wdt_pkg::WDT_MODE_RSEL_BIT] = reset_select_bit;
            end
            wdt_pkg::WDT_IDX_IRQ:
            begin
                next_rdata[wdt_pkg::WDT_IRQ_FLAG_BIT] = wd_irq_flag;
                next_rdata[wdt_pkg::WDT_IRQ_MASK_BIT] = wd_irq_mask;
                next_rdata[wdt_pkg::WDT_IRQ_PRIO_BIT] = wd_irq_priority;
            end
            default:
                next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hrdata <= '0;
        else if (addr_phase && !hwrite)
            hrdata <= {{(wdt_pkg::WDT_BUS_W - RW){1'h0}}, next_rdata};
    end

    // ----------------------------------------------------------------
    // period select register
    // ----------------------------------------------------------------
    // upper bits are not stored and read back as zero
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            period_sel <= wdt_pkg::WDT_PSEL_RST[wdt_pkg::WDT_PSEL_W-1:0];
        else if (wr_psel)
            period_sel <= wbyte[wdt_pkg::WDT_PSEL_W-1:0];
    end

    // ----------------------------------------------------------------
    // mode / restart register
    // ----------------------------------------------------------------
    assign restart = wr_mode & wbyte[wdt_pkg::WDT_MODE_RUN_BIT];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run <= wdt_pkg::WDT_MODE_RST[wdt_pkg::WDT_MODE_RUN_BIT];
            watchdog_enable_bit <= wdt_pkg::WDT_MODE_RST[
                wdt_pkg::WDT_MODE_EN_BIT];
            reset_select_bit <= wdt_pkg::WDT_MODE_RST[
                wdt_pkg::WDT_MODE_RSEL_BIT];
        end
        else if (wr_mode)
        begin
            // bits only ever set; a zero write cannot stop or leave a mode
            run <= run | wbyte[wdt_pkg::WDT_MODE_RUN_BIT];
            watchdog_enable_bit <= watchdog_enable_bit
                | wbyte[wdt_pkg::WDT_MODE_EN_BIT];
            reset_select_bit <= reset_select_bit
                | wbyte[wdt_pkg::WDT_MODE_RSEL_BIT];
        end
    end

    // decoded action on overflow
    always_comb
    begin
        if (!watchdog_enable_bit)
            mode = wdt_pkg::WDT_MODE_INTERVAL;
        else if (!reset_select_bit)
            mode = wdt_pkg::WDT_MODE_NMI;
        else
            mode = wdt_pkg::WDT_MODE_RESET;
    end

    // ----------------------------------------------------------------
    // interrupt flag, mask and priority register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wd_irq_mask <= wdt_pkg::WDT_IRQ_RST[wdt_pkg::WDT_IRQ_MASK_BIT];
            wd_irq_priority <= wdt_pkg::WDT_IRQ_RST[
                wdt_pkg::WDT_IRQ_PRIO_BIT];
        end
        else if (wr_irq)
        begin
            wd_irq_mask <= wbyte[wdt_pkg::WDT_IRQ_MASK_BIT];
            wd_irq_priority <= wbyte[wdt_pkg::WDT_IRQ_PRIO_BIT];
        end
    end

    // sticky; an overflow in the clearing cycle still sets it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            wd_irq_flag <= wdt_pkg::WDT_IRQ_RST[wdt_pkg::WDT_IRQ_FLAG_BIT];
        else if (overflow)
            wd_irq_flag <= 1'h1;
        else if (irq_ack)
            wd_irq_flag <= 1'h0;
        else if (wr_irq && !wbyte[wdt_pkg::WDT_IRQ_FLAG_BIT])
            wd_irq_flag <= 1'h0;
    end

    // ----------------------------------------------------------------
    // counting chain
    // ----------------------------------------------------------------
    // halt is not looked at: besides a clear run bit, only stop freezes the chain
    assign tk.run_en = run & ~stop_mode;

    wdt_prescale #(
        .PRE_BITS(PRE_BITS)
    ) u_prescale (
        .clk(clk),
        .reset_n(reset_n),
        .tk(tk)
    );

    function automatic logic [CNT_W-1:0] ovf_limit(input logic [4:0] e);
        logic [CNT_W:0] one;
        one = (CNT_W + 1)'(1);
        ovf_limit = CNT_W'((one << (e - 5'(PRE_BITS))) - one);
    endfunction

    assign limit = ovf_limit(OVF_EXP[period_sel]);
    assign at_limit = count == limit;
    // a restart in the same cycle wins over the overflow
    assign overflow = tk.tick & at_limit & ~restart;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            count <= '0;
        else if (restart)
            count <= '0;
        else if (tk.tick)
            count <= at_limit ? '0 : count + CNT_W'(1);
    end

    // ----------------------------------------------------------------
    // overflow actions
    // ----------------------------------------------------------------
    // flag already up when the watchdog bit goes from 0 to 1
    assign en_with_flag = wr_mode & wbyte[wdt_pkg::WDT_MODE_EN_BIT]
        & ~watchdog_enable_bit & wd_irq_flag;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nmi_req <= 1'h0;
            sys_reset_req <= 1'h0;
        end
        else
        begin
            nmi_req <= en_with_flag
                | (overflow & (mode == wdt_pkg::WDT_MODE_NMI));
            sys_reset_req <= overflow
                & (mode == wdt_pkg::WDT_MODE_RESET);
        end
    end

    // priority bit passed through; the controller ranks this source
    // first among maskable ones by default
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            wd_interval_irq <= 1'h0;
        else
            wd_interval_irq <= wd_irq_flag & ~wd_irq_mask
                & (mode == wdt_pkg::WDT_MODE_INTERVAL);
    end

endmodule // wdt_timer

/* testbench/wdt_timer_properties.sv */
`timescale 1ns/1ps
// ------------------------------
// port checks
// ------------------------------
module wdt_timer_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic stop_mode,
    input wire logic irq_ack,
    input wire logic wd_interval_irq,
    input wire logic wd_irq_priority,
    input wire logic nmi_req,
    input wire logic sys_reset_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic wr;
    assign wr = hsel & hready & htrans[1] & hwrite;
    // frozen pipeline needs a few cycles to drain
    sequence stop_held;
        stop_mode [*4];
    endsequence
    chk_nmi_spacing: assert property (nmi_req |=> !nmi_req [*8])
        else $error("nmi pulse too long or too close");
    chk_rst_spacing: assert property (sys_reset_req |=> !sys_reset_req [*8])
        else $error("reset pulse too long or too close");
    chk_one_action: assert property (!(nmi_req && sys_reset_req))
        else $error("nmi and reset together");
    chk_rst_no_irq: assert property (sys_reset_req |-> !wd_interval_irq)
        else $error("maskable irq in reset mode");
    chk_ack_clears: assert property (irq_ack |-> ##2 !wd_interval_irq)
        else $error("irq still high after ack");
    chk_irq_fall: assert property ($fell(wd_interval_irq) |->
        $past(irq_ack, 2) || $past(wr) || $past(wr, 2) || $past(wr, 3))
        else $error("irq dropped without ack or write");
    chk_stop_freeze: assert property (stop_held |->
        !nmi_req && !sys_reset_req && !$rose(wd_interval_irq))
        else $error("overflow while stopped");
    chk_prio_hold: assert property ($changed(wd_irq_priority) |->
        $past(wr) || $past(wr, 2) || $past(wr, 3))
        else $error("priority changed without write");
endmodule // wdt_timer_chk

bind wdt_timer wdt_timer_chk u_chk (.clk, .reset_n, .hsel, .htrans,
    .hwrite, .hready, .stop_mode, .irq_ack, .wd_interval_irq,
    .wd_irq_priority, .nmi_req, .sys_reset_req);

/* testbench/wdt_sys_model.sv */
`timescale 1ns/1ps
// ------------------------------
// interrupt controller and reset logic
// ------------------------------
module wdt_sys_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wd_interval_irq,
    input wire logic nmi_req,
    input wire logic sys_reset_req,
    input wire logic [3:0] ack_dly,
    output logic irq_ack
);
    int nmi_cnt = 0;
    int rst_cnt = 0;
    int wait_n;
    logic busy;
    logic irq_q;
    always @(posedge clk or negedge reset_n)
        if (!reset_n)
        begin
            irq_ack <= 1'h0;
            busy <= 1'h0;
            irq_q <= 1'h0;
        end
        else
        begin
            irq_ack <= 1'h0;
            irq_q <= wd_interval_irq;
            nmi_cnt <= nmi_cnt + int'(nmi_req);
            rst_cnt <= rst_cnt + int'(sys_reset_req);
            // only source here, so served first
            if (wd_interval_irq && !irq_q && !busy)
            begin
                busy <= 1'h1;
                wait_n <= int'(ack_dly);
            end
            else if (busy && wait_n == 0)
            begin
                irq_ack <= 1'h1;
                busy <= 1'h0;
            end
            else if (busy)
                wait_n <= wait_n - 1;
        end
endmodule // wdt_sys_model

/* testbench/watchdog_interval_timer_bench.sv */
`timescale 1ns/1ps
module watchdog_interval_timer_bench;
    localparam wdt_pkg::wdt_exp_tab_t EXP = {5'h0C, 5'h0B, 5'h0A, 5'h09,
                                             5'h08, 5'h07, 5'h06, 5'h05};
    localparam logic [29:0] SEL = wdt_pkg::WDT_IDX_PERIOD_SEL;
    localparam logic [29:0] MODE = wdt_pkg::WDT_IDX_MODE;
    localparam logic [29:0] IRQ = wdt_pkg::WDT_IDX_IRQ;
    logic clk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic halt_mode = 1'h0, stop_mode = 1'h0, irq_q = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [3:0] ack_dly = 4'h0;
    logic hreadyout, hresp, irq_ack, wd_interval_irq, wd_irq_priority;
    logic nmi_req, sys_reset_req;
    int mismatches = 0, compares = 0, m_sel, m_mode, m_irq, per, n, n0;
    int cyc = 0;
    int rises[$];
    always #2.5 clk = ~clk;
    wdt_timer #(.OVF_EXP(EXP), .PRE_BITS(4)) dut (.clk, .reset_n, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .halt_mode, .stop_mode, .irq_ack,
        .wd_interval_irq, .wd_irq_priority, .nmi_req, .sys_reset_req);
    wdt_sys_model u_sys (.clk, .reset_n, .wd_interval_irq, .nmi_req,
        .sys_reset_req, .ack_dly, .irq_ack);
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        irq_q <= wd_interval_irq;
        if (wd_interval_irq === 1'h1 && irq_q !== 1'h1)
            rises.push_back(cyc);
    end
    // ------------------------------
    // tasks
    // ------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic xfer(input logic [29:0] idx, input logic w,
                        input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [29:0] idx, input int d);
        xfer(idx, 1'h1, 32'(d));
        if (idx == SEL) m_sel = d & 8'h07;
        if (idx == MODE) m_mode |= d & 8'h98;
        if (idx == IRQ) m_irq = (d & 8'h06) | (m_irq & d & 8'h01);
    endtask
    task automatic rd_chk(input logic [29:0] idx, input int e);
        xfer(idx, 1'h0, 32'h0);
        check(rd, 32'(e));
        check(32'(hresp), 0);
    endtask
    task automatic hw_reset();
        reset_n <= 1'h0;
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        m_sel = 0;
        m_mode = 0;
        m_irq = 6;
    endtask
    function automatic logic sig(input int w);
        return w == 0 ? wd_interval_irq : w == 1 ? nmi_req : sys_reset_req;
    endfunction
    task automatic wait_for(input int w, input int lim);
        n = 0;
        while (sig(w) !== 1'h1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    initial
    begin
        void'($urandom(89521));
        hw_reset();
        rd_chk(SEL, 0);
        rd_chk(MODE, 0);
        rd_chk(IRQ, m_irq);
        rd_chk(30'h0000FF50, 0);
        wr(IRQ, 0);
        repeat (80) @(posedge clk);
        check(32'(rises.size()), 0);
        // every select code, stop needs a hardware reset
        for (int c = 0; c < 8; c++)
        begin
            hw_reset();
            per = 32 << c;
            ack_dly <= 4'($urandom % 8);
            wr(SEL, c);
            rd_chk(SEL, m_sel);
            wr(IRQ, 0);
            wr(MODE, 8'h80);
            wait_for(0, per + 8);
            check(32'(n >= per - 15 && n <= per + 4), 1);
            repeat (per + 8) @(posedge clk);
            check(32'(rises[$] - rises[$-1]), 32'(per));
        end
        hw_reset();
        per = 32 << ($urandom % 3);
        wr(SEL, $clog2(per) - 5);
        wr(IRQ, 0);
        // priority flop updates at the data-phase edge
        @(posedge clk);
        check(32'(wd_irq_priority), 0);
        wr(MODE, 8'h80);
        stop_mode <= 1'h1;
        repeat (4) @(posedge clk);
        n0 = rises.size();
        repeat (3 * per) @(posedge clk);
        check(32'(rises.size()), 32'(n0));
        stop_mode <= 1'h0;
        halt_mode <= 1'h1;
        repeat (3 * per) @(posedge clk);
        check(32'(rises.size() >= n0 + 2), 1);
        halt_mode <= 1'h0;
        wr(MODE, 0);
        rd_chk(MODE, m_mode);
        wr(IRQ, 2);
        // a rise launched just before the mask landed is not counted
        repeat (2) @(posedge clk);
        n0 = rises.size();
        repeat (per + 20) @(posedge clk);
        check(32'(rises.size()), 32'(n0));
        m_irq |= 1;
        rd_chk(IRQ, m_irq);
        n0 = u_sys.nmi_cnt;
        wr(MODE, 8'h98);
        repeat (3) @(posedge clk);
        check(32'(u_sys.nmi_cnt), 32'(n0 + 1));
        wr(IRQ, 2);
        wr(MODE, 8'h80);
        rd_chk(MODE, m_mode);
        repeat (4)
        begin
            // spacing kept under the earliest overflow, per - 15
            repeat (per / 4) @(posedge clk);
            wr(MODE, 8'h98);
        end
        check(32'(u_sys.rst_cnt), 0);
        wait_for(2, per + 8);
        check(32'(n <= per + 4 && u_sys.nmi_cnt == n0 + 1), 1);
        hw_reset();
        rd_chk(MODE, 0);
        rd_chk(IRQ, m_irq);
        wr(MODE, 8'h90);
        wait_for(1, 40);
        check(32'(n <= 36 && u_sys.rst_cnt == 1), 1);
        m_irq |= 1;
        rd_chk(IRQ, m_irq);
        check(32'(wd_interval_irq), 0);
        wrap_up();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule // watchdog_interval_timer_bench
